// ===== common/bc_seq_pkg.sv
`default_nettype none
package bc_seq_pkg;
    // ********************************************************
    // register map (byte addresses, one 32-bit word each)
    // ********************************************************
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_QPTR = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    localparam logic [7:0] ADDR_CONDITION = 8'h14;

    // ********************************************************
    // fields
    // ********************************************************
    localparam int CFG_BCAST_EN_BIT = 11;
    localparam int INT_ROLLOVER_BIT = 0;
    localparam int INT_FLIP_BIT = 1;
    localparam int INT_BITS = 2;
    localparam int FLAG_BITS = 8;
    localparam int FLAG_SET_LSB = 0;
    localparam int FLAG_CLR_LSB = 8;
    // message control word: status mask field and broadcast mask
    localparam int CTRL_MASK_MSB = 14;
    localparam int CTRL_MASK_LSB = 10;
    localparam int CTRL_RSV_MASK_BIT = 9;
    localparam int CTRL_BCAST_MASK_BIT = 5;
    // remote terminal status word positions (bit 0 = lsb)
    localparam int STAT_MSG_ERR = 10;
    localparam int STAT_INSTR = 9;
    localparam int STAT_SRQ = 8;
    localparam int STAT_RSV_MSB = 7;
    localparam int STAT_RSV_LSB = 5;
    localparam int STAT_BCAST_RX = 4;
    localparam int STAT_BUSY = 3;
    localparam int STAT_SUBSYS = 2;
    localparam int STAT_TFLAG = 0;

    // ********************************************************
    // condition codes, constants, reset values
    // ********************************************************
    localparam logic [3:0] CC_NORESP = 4'h8;
    localparam logic [3:0] CC_FMT_ERR = 4'h9;
    localparam logic [3:0] CC_GOOD_XFER = 4'ha;
    localparam logic [3:0] CC_MASKED = 4'hb;
    localparam logic [3:0] CC_BAD_MSG = 4'hc;
    localparam logic [3:0] CC_RETRY_LOW = 4'hd;
    localparam logic [3:0] CC_RETRY_HIGH = 4'he;
    localparam logic [3:0] CC_ALWAYS = 4'hf;
    localparam logic [15:0] FLIP_XOR = 16'h0010;
    localparam int QUEUE_DEPTH = 64;
    localparam int QIDX_BITS = 6;
    localparam logic [15:0] QUEUE_BASE_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [INT_BITS-1:0] INT_MASK_RESET = 2'h0;

    typedef enum logic [2:0] {
        op_none,
        execute_and_toggle_op,
        flag_update_op,
        push_time_tag_op,
        push_block_status_op,
        push_immediate_op,
        push_memory_op
    } op_t;
endpackage
`default_nettype wire

// ===== design/bc_sequencer_conditions_flip_queue.sv
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module bc_sequencer_conditions_flip_queue (
    input wire logic clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // latest message results from the message engine
    input wire logic [15:0] msg_ctrl_word,
    input wire logic [15:0] msg_status_word,
    input wire logic [15:0] msg_block_status,
    input wire logic msg_fmt_err,
    input wire logic msg_loop_fail,
    input wire logic msg_no_resp,
    input wire logic msg_good_xfer,
    input wire logic [1:0] msg_retries,
    input wire logic [15:0] time_tag,
    // instruction issue
    input wire logic instr_valid,
    input wire bc_seq_pkg::op_t instr_op,
    input wire logic [3:0] instr_cond,
    input wire logic instr_invert,
    input wire logic [15:0] instr_param,
    input wire logic [15:0] instr_param_addr,
    input wire logic [15:0] instr_mem_data,
    // results
    output logic cond_true,
    output logic exec_valid,
    output logic [15:0] exec_block_addr,
    output logic mem_wr_valid,
    output logic [15:0] mem_wr_addr,
    output logic [15:0] mem_wr_data,
    output logic irq
);
    import bc_seq_pkg::*;

    // ********************************************************
    // reset release
    // ********************************************************
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ********************************************************
    // state
    // ********************************************************
    logic [15:0] config_bits;
    logic [FLAG_BITS-1:0] flags;
    logic [QIDX_BITS-1:0] qidx;
    logic [15:0] queue_base;
    logic [INT_BITS-1:0] int_status;
    logic [INT_BITS-1:0] int_mask;
    logic [7:0] dp_addr;
    logic dp_write;
    logic [15:0] cc;
    logic masked_status_condition;
    logic bad_msg;
    logic retry_count_low;
    logic retry_count_high;
    logic sel_cond;
    logic is_push;
    logic [15:0] push_data;
    logic rollover_evt;
    logic flip_evt;
    logic host_wr;
    logic [7:0] op_set;
    logic [7:0] op_clr;
    logic [7:0] host_set;
    logic [7:0] host_clr;
    logic [7:0] all_set;
    logic [7:0] all_clr;
    logic [QIDX_BITS-1:0] next_qidx;

    // ********************************************************
    // condition codes
    // ********************************************************
    always_comb begin
        masked_status_condition =
            |(~msg_ctrl_word[CTRL_MASK_MSB:CTRL_MASK_LSB] &
              {msg_status_word[STAT_MSG_ERR], msg_status_word[STAT_BUSY],
               msg_status_word[STAT_SUBSYS], msg_status_word[STAT_TFLAG],
               msg_status_word[STAT_SRQ] | msg_status_word[STAT_INSTR]});
        if (!msg_ctrl_word[CTRL_RSV_MASK_BIT] &&
            |msg_status_word[STAT_RSV_MSB:STAT_RSV_LSB]) begin
            masked_status_condition = 1'b1;
        end
        if (config_bits[CFG_BCAST_EN_BIT] && !msg_ctrl_word[CTRL_BCAST_MASK_BIT] &&
            msg_status_word[STAT_BCAST_RX]) begin
            masked_status_condition = 1'b1;
        end
    end

    // status set is not an input here, so it cannot disturb this code
    assign bad_msg = msg_fmt_err | msg_loop_fail | msg_no_resp;
    // 2'b10 cannot be produced; a count of 3 is clamped to two
    assign retry_count_low = |msg_retries;
    assign retry_count_high = msg_retries[1];

    always_comb begin
        cc = {1'b1, retry_count_high, retry_count_low, bad_msg, masked_status_condition,
              msg_good_xfer, msg_fmt_err, msg_no_resp, flags};
        cc[CC_ALWAYS] = 1'b1;
    end

    assign sel_cond = cc[instr_cond] ^ instr_invert;

    // ********************************************************
    // instruction execution
    // ********************************************************
    assign is_push = instr_valid && (instr_op == push_time_tag_op ||
        instr_op == push_block_status_op || instr_op == push_immediate_op ||
        instr_op == push_memory_op);
    assign flip_evt = instr_valid && instr_op == execute_and_toggle_op && sel_cond;
    assign next_qidx = qidx + 6'h01;
    assign rollover_evt = is_push && qidx == 6'h3f;

    always_comb begin
        case (instr_op)
            push_time_tag_op: push_data = time_tag;
            push_block_status_op: push_data = msg_block_status;
            push_immediate_op: push_data = instr_param;
            push_memory_op: push_data = instr_mem_data;
            default: push_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cond_true <= 1'b0;
            exec_valid <= 1'b0;
            exec_block_addr <= 16'h0000;
        end else begin
            cond_true <= instr_valid ? sel_cond : cond_true;
            // the block runs whatever the condition says
            exec_valid <= instr_valid && instr_op == execute_and_toggle_op;
            if (instr_valid && instr_op == execute_and_toggle_op) begin
                exec_block_addr <= instr_param;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mem_wr_valid <= 1'b0;
            mem_wr_addr <= 16'h0000;
            mem_wr_data <= 16'h0000;
        end else begin
            mem_wr_valid <= flip_evt || is_push;
            if (flip_evt) begin
                mem_wr_addr <= instr_param_addr;
                mem_wr_data <= instr_param ^ FLIP_XOR;
            end else if (is_push) begin
                mem_wr_addr <= queue_base + {10'h000, qidx};
                mem_wr_data <= push_data;
            end
        end
    end

    // ********************************************************
    // ahb-lite slave: zero wait states, always okay
    // ********************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign host_wr = dp_write;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dp_addr <= 8'h00;
            dp_write <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            dp_write <= 1'b0;
            if (hsel && htrans[1] && hready) begin
                dp_addr <= haddr;
                dp_write <= hwrite;
                // read data is latched at the address phase
                case (haddr)
                    ADDR_CONFIG: hrdata <= {16'h0000, config_bits};
                    ADDR_FLAGS: hrdata <= {24'h000000, flags};
                    ADDR_QPTR: hrdata <= {16'h0000, queue_base + {10'h000, qidx}};
                    ADDR_INT_STATUS: hrdata <= {30'h00000000, int_status};
                    ADDR_INT_MASK: hrdata <= {30'h00000000, int_mask};
                    ADDR_CONDITION: hrdata <= {16'h0000, cc};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            config_bits <= CONFIG_RESET;
            int_mask <= INT_MASK_RESET;
        end else if (host_wr && dp_addr == ADDR_CONFIG) begin
            config_bits <= hwdata[15:0];
        end else if (host_wr && dp_addr == ADDR_INT_MASK) begin
            int_mask <= hwdata[INT_BITS-1:0];
        end
    end

    // ********************************************************
    // general purpose flags: set+clear together toggles
    // ********************************************************
    assign op_set = (instr_valid && instr_op == flag_update_op) ?
        instr_param[FLAG_SET_LSB +: 8] : 8'h00;
    assign op_clr = (instr_valid && instr_op == flag_update_op) ?
        instr_param[FLAG_CLR_LSB +: 8] : 8'h00;
    assign host_set = (host_wr && dp_addr == ADDR_FLAGS) ? hwdata[FLAG_SET_LSB +: 8] : 8'h00;
    assign host_clr = (host_wr && dp_addr == ADDR_FLAGS) ? hwdata[FLAG_CLR_LSB +: 8] : 8'h00;
    assign all_set = op_set | host_set;
    assign all_clr = op_clr | host_clr;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags <= 8'h00;
        end else begin
            flags <= (flags & ~(all_set | all_clr)) | (all_set & ~all_clr) |
                     (~flags & all_set & all_clr);
        end
    end

    // ********************************************************
    // queue pointer: write sets base and index together
    // ********************************************************
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            qidx <= 6'h00;
            queue_base <= QUEUE_BASE_RESET;
        end else if (host_wr && dp_addr == ADDR_QPTR) begin
            queue_base <= {hwdata[15:QIDX_BITS], 6'h00};
            qidx <= hwdata[QIDX_BITS-1:0];
        end else if (is_push) begin
            qidx <= next_qidx;
        end
    end

    // ********************************************************
    // interrupts: sticky, write one to clear, set wins
    // ********************************************************
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            int_status <= '0;
        end else begin
            if (host_wr && dp_addr == ADDR_INT_STATUS) begin
                int_status <= int_status & ~hwdata[INT_BITS-1:0];
            end
            if (rollover_evt) begin
                int_status[INT_ROLLOVER_BIT] <= 1'b1;
            end
            if (flip_evt) begin
                int_status[INT_FLIP_BIT] <= 1'b1;
            end
        end
    end

    assign irq = |(int_status & int_mask);

    // ********************************************************
    // checks
    // ********************************************************
    sequence s_flip_issue;
        instr_valid && instr_op == execute_and_toggle_op && sel_cond;
    endsequence

    a_flip_write_data: assert property (@(posedge clk) disable iff (!rst_sync_n)
        s_flip_issue |=> mem_wr_valid && mem_wr_data == ($past(instr_param) ^ 16'h0010))
        else $error("flip write data wrong");
    a_false_no_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (instr_valid && instr_op == execute_and_toggle_op && !sel_cond) |=> !mem_wr_valid)
        else $error("false flip wrote memory");
    a_block_current: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (instr_valid && instr_op == execute_and_toggle_op) |=>
        exec_valid && exec_block_addr == $past(instr_param))
        else $error("block address not current pointer");
    a_skip_skip_condition: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (instr_valid && instr_cond == 4'hf) |=> cond_true == !$past(instr_invert))
        else $error("always or skip_condition wrong");
    a_queue_advance: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (is_push && !(host_wr && dp_addr == ADDR_QPTR)) |=> qidx == $past(qidx) + 6'h01)
        else $error("queue pointer did not advance");
    a_rollover_flag: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (is_push && qidx == 6'h3f && !(host_wr && dp_addr == ADDR_QPTR)) |=>
        int_status[INT_ROLLOVER_BIT] ##0 qidx == 6'h00)
        else $error("rollover not flagged");
    a_masked_rsv: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (!msg_ctrl_word[9] && |msg_status_word[7:5]) |-> masked_status_condition)
        else $error("reserved bits not masked status");
    a_bad_message: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cc[CC_BAD_MSG] == (msg_fmt_err || msg_loop_fail || msg_no_resp))
        else $error("bad message code wrong");
    a_retry_code: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cc[CC_RETRY_HIGH:CC_RETRY_LOW] == ((msg_retries == 2'h0) ? 2'b00 :
        (msg_retries == 2'h1) ? 2'b01 : 2'b11))
        else $error("retry code wrong");
endmodule
`default_nettype wire

// ===== tb/bc_sequencer_conditions_flip_queue_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module bc_sequencer_conditions_flip_queue_tb;
    import bc_seq_pkg::*;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, instr_valid, instr_invert;
    logic msg_fmt_err, msg_loop_fail, msg_no_resp, msg_good_xfer, cond_true, exec_valid;
    logic mem_wr_valid, irq, cfg_b, inv;
    logic [1:0] htrans, msg_retries;
    logic [2:0] hsize;
    logic [3:0] instr_cond, c;
    logic [7:0] haddr, flags;
    logic [15:0] msg_ctrl_word, msg_status_word, msg_block_status, time_tag, instr_param;
    logic [15:0] param_r, instr_param_addr, instr_mem_data, exec_block_addr, mem_wr_addr;
    logic [15:0] mem_wr_data, mem_rd, p, v, exp_d;
    logic [31:0] hwdata, hrdata, rd;
    op_t instr_op, op;
    int error_cnt = 0;
    int total_checks = 0;
    logic [7:0] ra [6] = '{ADDR_CONFIG, ADDR_FLAGS, ADDR_QPTR, ADDR_INT_STATUS, ADDR_INT_MASK,
                           8'h3c};

    // the engine fetches the toggle pointer from memory, other params are immediates
    assign instr_param = (instr_op == execute_and_toggle_op) ? mem_rd : param_r;
    assign instr_mem_data = mem_rd;
    assign hready = hreadyout;

    bc_sequencer_conditions_flip_queue i_dut (
        .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .msg_ctrl_word, .msg_status_word, .msg_block_status,
        .msg_fmt_err, .msg_loop_fail, .msg_no_resp, .msg_good_xfer, .msg_retries, .time_tag,
        .instr_valid, .instr_op, .instr_cond, .instr_invert, .instr_param, .instr_param_addr,
        .instr_mem_data, .cond_true, .exec_valid, .exec_block_addr, .mem_wr_valid,
        .mem_wr_addr, .mem_wr_data, .irq
    );
    msg_memory_model i_mem (
        .clk, .wr_valid(mem_wr_valid), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data),
        .rd_addr(instr_param_addr), .rd_data(mem_rd)
    );

    // ********************************************************
    // expectations
    // ********************************************************
    function automatic logic [15:0] cond_vec();
        logic [15:0] k, s, r;
        k = msg_ctrl_word;
        s = msg_status_word;
        r[7:0] = flags;
        r[8] = msg_no_resp;
        r[9] = msg_fmt_err;
        r[10] = msg_good_xfer;
        r[11] = (!k[14] & s[10]) | (!k[13] & s[3]) | (!k[12] & s[2]) | (!k[11] & s[0]);
        r[11] = r[11] | (!k[10] & (s[8] | s[9])) | (!k[9] & (|s[7:5]));
        r[11] = r[11] | (cfg_b & !k[5] & s[4]);
        r[12] = msg_fmt_err | msg_loop_fail | msg_no_resp;
        r[13] = (msg_retries != 2'h0);
        r[14] = msg_retries[1];
        r[15] = 1'b1;
        return r;
    endfunction

    // set and clear together toggle, as for the host register
    function automatic logic [7:0] flag_next(logic [7:0] f, logic [15:0] q);
        return (f & ~(q[7:0] | q[15:8])) | (q[7:0] & ~q[15:8]) | (q[7:0] & q[15:8] & ~f);
    endfunction

    // ********************************************************
    // drivers
    // ********************************************************
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        // a write lands at this edge: let it settle before callers look at irq
        #1;
    endtask

    task automatic instr(input op_t o, input logic [3:0] k, input logic i, input logic [15:0] q,
                         input logic [15:0] a);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= o;
        instr_cond <= k;
        instr_invert <= i;
        param_r <= q;
        instr_param_addr <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic rand_msg();
        @(posedge clk);
        msg_ctrl_word <= 16'($urandom | $urandom);
        msg_status_word <= 16'($urandom & $urandom);
        msg_block_status <= 16'($urandom);
        {msg_fmt_err, msg_loop_fail, msg_no_resp, msg_good_xfer} <= 4'($urandom);
        msg_retries <= 2'($urandom);
        time_tag <= 16'($urandom);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    // ********************************************************
    // scenarios
    // ********************************************************
    initial begin
        {rst_n, hsel, hwrite, instr_valid, instr_invert, cfg_b} = '0;
        {htrans, msg_retries, instr_cond, haddr, flags, msg_ctrl_word} = '0;
        {msg_fmt_err, msg_loop_fail, msg_no_resp, msg_good_xfer} = '0;
        {msg_status_word, msg_block_status, time_tag, param_r, instr_param_addr, hwdata} = '0;
        hsize = 3'b010;
        instr_op = op_none;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        void'($urandom(32'h52a1));
        foreach (ra[i]) begin
            ahb(1'b0, ra[i], 32'h0);
            `CHK({hreadyout, hresp, rd}, {2'b10, 32'h0})
        end
        // condition codes under random message results
        for (int i = 0; i < 40; i++) begin
            if (i % 10 == 0) begin
                cfg_b = 1'($urandom);
                ahb(1'b1, ADDR_CONFIG, 32'(cfg_b) << CFG_BCAST_EN_BIT);
            end
            rand_msg();
            c = 4'(8 + $urandom_range(7));
            inv = 1'($urandom);
            instr(op_none, c, inv, 16'h0, 16'h0);
            v = cond_vec();
            `CHK(cond_true, v[c] ^ inv)
            ahb(1'b0, ADDR_CONDITION, 32'h0);
            `CHK(rd, {16'h0, v})
        end
        instr(op_none, CC_ALWAYS, 1'b1, 16'h0, 16'h0);
        `CHK(cond_true, 1'b0)
        // flags from host and from the flag op
        for (int i = 0; i < 10; i++) begin
            p = 16'($urandom);
            if (i[0]) begin
                ahb(1'b1, ADDR_FLAGS, {16'h0, p});
            end else begin
                instr(flag_update_op, 4'h0, 1'b0, p, 16'h0);
            end
            flags = flag_next(flags, p);
            ahb(1'b0, ADDR_FLAGS, 32'h0);
            `CHK(rd, {24'h0, flags})
            c = 4'($urandom_range(7));
            instr(op_none, c, i[1], 16'h0, 16'h0);
            `CHK(cond_true, flags[c[2:0]] ^ i[1])
        end
        // execute and toggle: true twice, then false
        instr(execute_and_toggle_op, CC_ALWAYS, 1'b0, 16'h0, 16'h0020);
        `CHK({exec_valid, exec_block_addr}, {1'b1, 16'ha520})
        `CHK({mem_wr_valid, mem_wr_addr, mem_wr_data}, {1'b1, 16'h0020, 16'ha530})
        `CHK(irq, 1'b0)
        instr(execute_and_toggle_op, CC_ALWAYS, 1'b0, 16'h0, 16'h0020);
        `CHK({exec_block_addr, mem_wr_data}, {16'ha530, 16'ha520})
        instr(execute_and_toggle_op, CC_ALWAYS, 1'b1, 16'h0, 16'h0020);
        `CHK({exec_valid, cond_true, mem_wr_valid, exec_block_addr}, {3'b100, 16'ha520})
        ahb(1'b0, ADDR_INT_STATUS, 32'h0);
        `CHK(rd, 32'h2)
        ahb(1'b1, ADDR_INT_MASK, 32'h3);
        `CHK(irq, 1'b1)
        ahb(1'b1, ADDR_INT_STATUS, 32'h2);
        `CHK(irq, 1'b0)
        // queue pushes across a rollover
        ahb(1'b1, ADDR_QPTR, 32'h40);
        for (int i = 0; i < 66; i++) begin
            rand_msg();
            op = op_t'(3 + $urandom_range(3));
            p = 16'($urandom);
            // fetch from 0x80..0xff, clear of the queue words written at 0x40..0x7f
            instr(op, 4'h0, 1'b0, p, {9'h001, 7'($urandom)});
            case (op)
                push_time_tag_op: exp_d = time_tag;
                push_block_status_op: exp_d = msg_block_status;
                push_immediate_op: exp_d = p;
                default: exp_d = {8'ha5, instr_param_addr[7:0]};
            endcase
            `CHK({mem_wr_valid, mem_wr_addr, mem_wr_data}, {1'b1, 16'(64 + i % 64), exp_d})
            `CHK(irq, 1'(i >= 63))
            ahb(1'b0, ADDR_QPTR, 32'h0);
            `CHK(rd, 32'(64 + (i + 1) % 64))
        end
        ahb(1'b1, ADDR_INT_STATUS, 32'h1);
        `CHK(irq, 1'b0)
        stop_test();
    end
endmodule
`default_nettype wire

// ===== tb/msg_memory_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********************************************************
// shared memory on the engine side of the sequencer
// ********************************************************
module msg_memory_model (
    input wire logic clk,
    input wire logic wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [256];
    // every word starts distinct so a wrong address shows as a wrong value
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'ha5, i[7:0]};
        end
    end
    // a rewritten pointer is what the next run of that entry fetches
    always @(posedge clk) begin
        if (wr_valid) begin
            mem[wr_addr[7:0]] <= wr_data;
        end
    end
    assign rd_data = mem[rd_addr[7:0]];
endmodule
`default_nettype wire
